// ==== logic/rate_divider_regs.svh ====
`ifndef RATE_DIVIDER_REGS_SVH
`define RATE_DIVIDER_REGS_SVH
// register byte addresses
`define ADDR_TX_CTRL       12'h000
`define ADDR_RX_CTRL       12'h004
`define ADDR_RATE_CTRL     12'h008
`define ADDR_DIV_HIGH      12'h00C
`define ADDR_DIV_LOW       12'h010
`define ADDR_STATUS        12'h014
// field positions
`define BIT_SYNC_MODE      4
`define BIT_HIGH_SPEED     2
`define BIT_PORT_ENABLE    7
`define BIT_WIDE_DIVIDER   3
// reset values
`define RST_TX_CTRL        8'h00
`define RST_RX_CTRL        8'h00
`define RST_RATE_CTRL      8'h00
`define RST_DIV_BYTE       8'h00
// divider factors, in sample ticks per bit
`define FACTOR_64          7'h40
`define FACTOR_16          7'h10
`define FACTOR_4           7'h04
`endif

// ==== logic/rate_divider_pkg.sv ====
package rate_divider_pkg;
  // divider mode decoded from the select bits
  typedef enum logic [1:0] {
    mode_div64,
    mode_div16,
    mode_div4
  } rate_mode_t;
endpackage : rate_divider_pkg

// ==== logic/majority_sampler.sv ====
// three-sample majority vote on the synchronised receive line
module majority_sampler
  import rate_divider_pkg::*;
(
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // sampling
  input  wire logic sample_en,
  input  wire logic line_sync,
  output logic      level_q
);
  logic [2:0] samples_q;

  // shift in one sample per enable
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      samples_q <= 3'h7;
    else if (sample_en)
      samples_q <= {samples_q[1:0], line_sync};
  end

  // majority of the three samples
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level_q <= 1'b1;
    else
      level_q <= (samples_q[0] & samples_q[1]) | (samples_q[0] & samples_q[2])
                 | (samples_q[1] & samples_q[2]);
  end
endmodule : majority_sampler

// ==== logic/serial_baud_rate_generator.sv ====
// Function
// - async 8-bit low speed: osc/(64(n+1))
// - async 16-bit low speed: osc/(16(n+1))
// - sync mode: osc/(4(n+1)) always
// - divisor is high byte over low byte
// - receive level by three-sample majority
// - narrow divider ignores high byte
// - divisor write restarts the counter
// - high speed ignored in sync mode
`include "rate_divider_regs.svh"
module serial_baud_rate_generator
  import rate_divider_pkg::*;
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial side
  input  wire logic        receive_data_pin,
  output logic             bit_tick_q,
  output logic             sample_tick_q,
  output logic             receive_level_q
);
  // register copies
  logic [7:0]  tx_ctrl_q;
  logic [7:0]  rx_ctrl_q;
  logic [7:0]  rate_ctrl_q;
  logic [7:0]  divisor_high_byte_q;
  logic [7:0]  divisor_low_byte_q;
  // divider state
  logic [15:0] count_q;
  logic [6:0]  phase_q;
  logic        restart_q;
  // receive path
  logic [1:0]  rx_sync_q;
  logic        level;
  // bus decode and rate selection
  logic        wr_en;
  logic        rd_en;
  logic [15:0] divisor;
  logic [6:0]  factor;
  rate_mode_t  mode;

  // decode one register address as mapped
  function automatic logic mapped(input logic [11:0] a);
    mapped = (a == `ADDR_TX_CTRL) || (a == `ADDR_RX_CTRL) || (a == `ADDR_RATE_CTRL)
             || (a == `ADDR_DIV_HIGH) || (a == `ADDR_DIV_LOW) || (a == `ADDR_STATUS);
  endfunction : mapped

  // registers whose write restarts the divider
  function automatic logic restarting(input logic [11:0] a);
    restarting = (a == `ADDR_DIV_HIGH) || (a == `ADDR_DIV_LOW) || (a == `ADDR_TX_CTRL)
                 || (a == `ADDR_RATE_CTRL);
  endfunction : restarting

  // access strobes: a write lands on the completing edge, with pready high;
  // read data is registered one edge earlier so it stands with pready
  assign wr_en = psel & penable & pwrite & pready;
  assign rd_en = psel & penable & ~pwrite & ~pready;

  // pick divisor and factor from mode bits
  always_comb
  begin
    if (rate_ctrl_q[`BIT_WIDE_DIVIDER])
      divisor = {divisor_high_byte_q, divisor_low_byte_q};
    else
      divisor = {8'h00, divisor_low_byte_q};
    if (tx_ctrl_q[`BIT_SYNC_MODE])
      mode = mode_div4;
    else if (rate_ctrl_q[`BIT_WIDE_DIVIDER])
      mode = tx_ctrl_q[`BIT_HIGH_SPEED] ? mode_div4 : mode_div16;
    else
      mode = tx_ctrl_q[`BIT_HIGH_SPEED] ? mode_div16 : mode_div64;
    case (mode)
      mode_div64: factor = `FACTOR_64;
      mode_div16: factor = `FACTOR_16;
      mode_div4:  factor = `FACTOR_4;
      default:    factor = `FACTOR_64;
    endcase
  end

  // apb handshake, one wait state: pready rises the cycle after
  // the first access edge and falls at the next
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped(paddr);
    end
  end

  // control register writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_ctrl_q           <= `RST_TX_CTRL;
      rx_ctrl_q           <= `RST_RX_CTRL;
      rate_ctrl_q         <= `RST_RATE_CTRL;
      divisor_high_byte_q <= `RST_DIV_BYTE;
      divisor_low_byte_q  <= `RST_DIV_BYTE;
    end
    else if (wr_en)
    begin
      case (paddr)
        `ADDR_TX_CTRL:   tx_ctrl_q           <= pwdata[7:0];
        `ADDR_RX_CTRL:   rx_ctrl_q           <= pwdata[7:0];
        `ADDR_RATE_CTRL: rate_ctrl_q         <= pwdata[7:0] & 8'hFB; // bit 2 unused
        `ADDR_DIV_HIGH:  divisor_high_byte_q <= pwdata[7:0];
        `ADDR_DIV_LOW:   divisor_low_byte_q  <= pwdata[7:0];
        default:         ;
      endcase
    end
  end

  // divisor write or mode write requests a restart
  // mode bits change the factor, so their writes restart the count too
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      restart_q <= 1'b1;
    else
      restart_q <= wr_en && restarting(paddr);
  end

  // read mux, registered so data stands with pready
  // unmapped places read as zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_en)
    begin
      case (paddr)
        `ADDR_TX_CTRL:   prdata <= {24'h000000, tx_ctrl_q};
        `ADDR_RX_CTRL:   prdata <= {24'h000000, rx_ctrl_q};
        `ADDR_RATE_CTRL: prdata <= {24'h000000, rate_ctrl_q};
        `ADDR_DIV_HIGH:  prdata <= {24'h000000, divisor_high_byte_q};
        `ADDR_DIV_LOW:   prdata <= {24'h000000, divisor_low_byte_q};
        `ADDR_STATUS:    prdata <= {29'h0000000, receive_level_q, sample_tick_q, bit_tick_q};
        default:         prdata <= 32'h0000_0000;
      endcase
    end
  end

  // prescale by divisor+1, then count factor prescaled ticks per bit
  // port enable low holds the generator idle, like a port reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      phase_q       <= 7'h00;
      count_q       <= 16'h0000;
      bit_tick_q    <= 1'b0;
      sample_tick_q <= 1'b0;
    end
    else if (restart_q || !rx_ctrl_q[`BIT_PORT_ENABLE])
    begin
      phase_q       <= 7'h00;
      count_q       <= 16'h0000;
      bit_tick_q    <= 1'b0;
      sample_tick_q <= 1'b0;
    end
    else
    begin
      bit_tick_q    <= 1'b0;
      sample_tick_q <= 1'b0;
      if (count_q >= divisor)
      begin
        count_q       <= 16'h0000;
        sample_tick_q <= 1'b1;
        if (phase_q >= factor - 7'h01)
        begin
          phase_q    <= 7'h00;
          bit_tick_q <= 1'b1;
        end
        else
          phase_q <= phase_q + 7'h01;
      end
      else
        count_q <= count_q + 16'h0001;
    end
  end

  // two-flop synchroniser on the receive pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_sync_q <= 2'h3;
    else
      rx_sync_q <= {rx_sync_q[0], receive_data_pin};
  end

  majority_sampler u_vote (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (sample_tick_q),
    .line_sync (rx_sync_q[1]),
    .level_q   (level)
  );

  // registered copy of the vote
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      receive_level_q <= 1'b1;
    else
      receive_level_q <= level;
  end
endmodule : serial_baud_rate_generator

// ==== testbench/serial_baud_rate_generator_props.sv ====
module serial_baud_rate_generator_props (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave side
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] prdata,
  // serial side
  input  wire logic        bit_tick_q,
  input  wire logic        receive_level_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // access edge still waiting
  wire logic acc = psel && penable && !pready;
  chk_ready_next: assert property (acc |=> pready) else $error("late");
  chk_ready_once: assert property (pready |=> !pready) else $error("held");
  chk_ready_sel: assert property (pready |-> psel && penable) else $error("stray");
  chk_err_read: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0) else $error("e");
  chk_err_unmap: assert property (acc && paddr > 12'h014 |=> pslverr) else $error("no err");
  chk_tick_gap: assert property (bit_tick_q |=> !bit_tick_q [*3]) else $error("gap");
  chk_div_restart: assert property (psel && penable && pready && pwrite
    && paddr inside {12'h00C, 12'h010} |=> ##1 !bit_tick_q [*3]) else $error("restart");
  chk_level_init: assert property ($rose(presetn) |-> receive_level_q) else $error("lvl");
  // main scenarios
  cover property (bit_tick_q);
  cover property (pslverr);
  cover property ($fell(receive_level_q));
endmodule : serial_baud_rate_generator_props
bind serial_baud_rate_generator serial_baud_rate_generator_props u_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .prdata, .bit_tick_q, .receive_level_q);

// ==== testbench/remote_line_model.sv ====
module remote_line_model (
  // clock
  input  wire logic       pclk,
  // low pulse request
  input  wire logic       start,
  input  wire logic [3:0] low_len,
  // receive line towards the block
  output logic            rx
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q = 4'h0;
  // line low for low_len cycles, else idle high
  always_ff @(posedge pclk)
    if (start) cnt_q <= low_len;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  assign rx = (cnt_q == 4'h0);
endmodule : remote_line_model

// ==== testbench/serial_baud_rate_generator_tb_top.sv ====
module serial_baud_rate_generator_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, start = 0, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [3:0]  low_len = 0;
  logic        pready, pslverr, rx, bit_tick_q, sample_tick_q, receive_level_q;
  int          bad_count = 0, checks = 0, cyc = 0, t0, hb, n;
  // clock
  always #2.5 pclk = ~pclk;
  serial_baud_rate_generator u_serial_baud_rate_generator (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .receive_data_pin(rx),
    .bit_tick_q, .sample_tick_q, .receive_level_q);
  remote_line_model u_remote_line_model (.pclk, .start, .low_len, .rx);
  // verdict
  task end_of_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // cycle count and hang guard
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      bad_count++;
      end_of_test;
    end
  end
  task check(input logic [31:0] seen, exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  // one transfer held until pready
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    @(posedge pclk iff pready === 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  function int factor(input int m);
    return m[2] ? 4 : m[1] ? (m[0] ? 4 : 16) : (m[0] ? 16 : 64);
  endfunction : factor
  initial
  begin
    void'($urandom(32'hB544));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    // reset values, unmapped place last
    for (int a = 0; a < 7; a++)
    begin
      apb(0, 12'(4 * a), 0);
      check(rd, (a == 5) ? 32'h4 : 32'h0, "reset");
      check(err, 32'(a == 6), "error");
    end
    apb(1, 12'h004, 32'h80);
    // every mode, random divisor
    for (int m = 0; m < 8; m++)
    begin
      n = $urandom_range(7);
      hb = $urandom_range(2, 1);
      apb(1, 12'h000, 32'(m[2] * 16 + m[0] * 4));
      apb(1, 12'h008, 32'(m[1] * 8));
      apb(1, 12'h00C, hb);
      apb(1, 12'h010, n);
      // let the restart clear any stale tick
      @(posedge pclk);
      @(posedge pclk iff bit_tick_q === 1'b1);
      t0 = cyc;
      @(posedge pclk iff bit_tick_q === 1'b1);
      check(cyc - t0, factor(m) * ((m[1] ? hb * 256 : 0) + n + 1), "period");
      // prescaler tick spacing is the divisor plus one
      @(posedge pclk iff sample_tick_q === 1'b1);
      t0 = cyc;
      @(posedge pclk iff sample_tick_q === 1'b1);
      check(cyc - t0, (m[1] ? hb * 256 : 0) + n + 1, "sample period");
    end
    apb(1, 12'h00C, 0);
    apb(1, 12'h010, 0);
    // glitch then long low
    for (int k = 1; k < 13; k += 11)
    begin
      low_len <= 4'(k);
      start <= 1;
      @(posedge pclk) start <= 0;
      repeat (9) @(posedge pclk) if (k == 1) check(receive_level_q, 1, "glitch");
      check(receive_level_q, 32'(k == 1), "level");
    end
    end_of_test;
  end
endmodule : serial_baud_rate_generator_tb_top
